// ---- logic/iaseq_top.sv ----
// Interrupt accept sequencer: request flags, priority chain, entry and return
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module iaseq_top
    import iaseq_pkg::*;
#(
    parameter logic [NSRC*PC_W-1:0] VECTORS = VEC_DEFAULT
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NSRC-1:0]   src_event,
    input  wire logic              pin_reset,
    input  wire logic              wdt_reset,
    input  wire logic              stack_fault_reset,
    input  wire logic              ce_reset,
    input  wire iaseq_op_t         instr_op,
    input  wire logic [PC_W-1:0]   next_pc,
    input  wire logic [CTX_W-1:0]  sys_ctx,
    output logic                   instr_tick,
    output logic                   irq_cycle,
    output logic                   global_irq_enable_ff,
    output logic                   pc_load,
    output logic      [PC_W-1:0]   pc_value,
    output logic                   ctx_load,
    output logic      [CTX_W-1:0]  ctx_value,
    output logic      [CTX_W-1:0]  ctx_mask,
    output logic      [SP_W-1:0]   stack_ptr
);

    // ==========================================================
    // Helpers
    function automatic logic [SRC_IDX_W-1:0] chain_winner(input logic [NSRC-1:0] act);
        logic [SRC_IDX_W-1:0] w;
        w = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (act[i]) begin
                w = SRC_IDX_W'(i);
            end
        end
        return w;
    endfunction

    function automatic logic [PC_W-1:0] vector_of(input logic [SRC_IDX_W-1:0] idx);
        return VECTORS[idx*PC_W +: PC_W];
    endfunction

    // ==========================================================
    // State
    logic [ICYC_CNT_W-1:0] cyc_cnt_r;
    logic                  tick_r;
    logic                  gie_r;
    logic                  icyc_r;
    logic [NSRC-1:0]       req_flag_r;
    logic [NSRC-1:0]       src_en_r;
    logic [SRC_IDX_W-1:0]  win_idx_r;
    logic [PC_W-1:0]       saved_pc_r;
    logic [CTX_W-1:0]      saved_ctx_r;
    logic [SP_W-1:0]       sp_r;
    logic [PC_W-1:0]       astk_r [ASTK_N];
    logic [CTX_W-1:0]      istk_r [ISTK_N];
    logic [ISTK_D_W-1:0]   idepth_r;
    logic                  pc_load_r;
    logic [PC_W-1:0]       pc_value_r;
    logic                  ctx_load_r;
    logic [CTX_W-1:0]      ctx_value_r;
    logic [CTX_W-1:0]      ctx_mask_r;
    logic [31:0]           prdata_r;
    logic                  pready_r;
    logic                  pslverr_r;

    logic                  any_sys_rst;
    logic                  boundary;
    logic [NSRC-1:0]       pend_w;
    logic [SRC_IDX_W-1:0]  win_w;
    logic                  gie_eff;
    logic                  defer_w;
    logic                  accept_now;
    logic                  entry_done;
    logic                  is_ret;
    logic                  wr_en;
    logic [NSRC-1:0]       flag_w1c;
    logic [SP_W-1:0]       sp_dec;
    logic [PC_W-1:0]       top_pc_w;

    assign any_sys_rst = pin_reset | wdt_reset | stack_fault_reset | ce_reset;
    assign boundary    = tick_r & ~icyc_r;
    assign pend_w      = req_flag_r & src_en_r;
    assign win_w       = chain_winner(pend_w);
    assign gie_eff     = gie_r & (instr_op != OP_DI);
    // Table read first half and taken skip hold acceptance one more cycle
    assign defer_w     = (instr_op == OP_MOVT1) | (instr_op == OP_SKIP);
    assign is_ret      = (instr_op == OP_IRQ_RETURN_INSTR) | (instr_op == OP_RET) |
                         (instr_op == OP_SUBROUTINE_RETURN_SKIP_INSTR);
    // Returns also defer: pop and push in one boundary would race the pointer
    assign accept_now  = boundary & gie_eff & (|pend_w) & ~defer_w & ~is_ret &
                         ~any_sys_rst;
    assign entry_done  = tick_r & icyc_r;
    assign sp_dec      = sp_r - SP_W'(1);
    assign top_pc_w    = astk_r[sp_r];
    assign wr_en       = psel & penable & pready_r & pwrite;
    assign flag_w1c    = (wr_en && paddr == REG_REQ_FLAGS) ? pwdata[NSRC-1:0] : '0;

    // ==========================================================
    // Instruction cycle divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt_r <= '0;
            tick_r    <= 1'b0;
        end else begin
            tick_r <= (cyc_cnt_r == ICYC_LAST);
            if (cyc_cnt_r == ICYC_LAST) begin
                cyc_cnt_r <= '0;
            end else begin
                cyc_cnt_r <= cyc_cnt_r + ICYC_CNT_W'(1);
            end
        end
    end

    // ==========================================================
    // Global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gie_r <= 1'b0;
        end else if (any_sys_rst) begin
            gie_r <= 1'b0;
        end else if (accept_now) begin
            gie_r <= 1'b0;
        end else if (boundary && instr_op == OP_DI) begin
            gie_r <= 1'b0;
        end else if (boundary && instr_op == OP_EI) begin
            // Becomes visible for the following instruction only
            gie_r <= 1'b1;
        end
    end

    // ==========================================================
    // Request flags: a new event beats any clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_flag_r <= '0;
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (src_event[i]) begin
                    req_flag_r[i] <= 1'b1;
                end else if (flag_w1c[i] || (accept_now && win_w == SRC_IDX_W'(i))) begin
                    req_flag_r[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Interrupt cycle and captured entry data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            icyc_r      <= 1'b0;
            win_idx_r   <= '0;
            saved_pc_r  <= '0;
            saved_ctx_r <= '0;
        end else if (accept_now) begin
            icyc_r      <= 1'b1;
            win_idx_r   <= win_w;
            saved_pc_r  <= next_pc;
            saved_ctx_r <= sys_ctx;
        end else if (entry_done) begin
            icyc_r <= 1'b0;
        end
    end

    // ==========================================================
    // Address stack and pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_r <= SP_RST;
            for (int i = 0; i < ASTK_N; i++) begin
                astk_r[i] <= '0;
            end
        end else if (entry_done) begin
            sp_r         <= sp_dec;
            astk_r[sp_dec] <= saved_pc_r;
        end else if (boundary && is_ret) begin
            sp_r <= sp_r + SP_W'(1);
        end
    end

    // ==========================================================
    // Context stack: four levels, oldest falls off the bottom
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idepth_r <= '0;
            for (int i = 0; i < ISTK_N; i++) begin
                istk_r[i] <= '0;
            end
        end else if (entry_done) begin
            istk_r[0] <= saved_ctx_r;
            for (int i = 1; i < ISTK_N; i++) begin
                istk_r[i] <= istk_r[i-1];
            end
            if (idepth_r != ISTK_D_W'(ISTK_N)) begin
                idepth_r <= idepth_r + ISTK_D_W'(1);
            end
        end else if (boundary && instr_op == OP_IRQ_RETURN_INSTR) begin
            for (int i = 0; i < ISTK_N - 1; i++) begin
                istk_r[i] <= istk_r[i+1];
            end
            istk_r[ISTK_N-1] <= '0;
            if (idepth_r != '0) begin
                idepth_r <= idepth_r - ISTK_D_W'(1);
            end
        end
    end

    // ==========================================================
    // Sequencer outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_load_r   <= 1'b0;
            pc_value_r  <= '0;
            ctx_load_r  <= 1'b0;
            ctx_value_r <= '0;
            ctx_mask_r  <= '0;
        end else begin
            pc_load_r  <= 1'b0;
            ctx_load_r <= 1'b0;
            if (entry_done) begin
                pc_load_r  <= 1'b1;
                pc_value_r <= vector_of(win_idx_r);
            end else if (boundary && is_ret) begin
                pc_load_r   <= 1'b1;
                pc_value_r  <= top_pc_w;
                ctx_load_r  <= 1'b1;
                ctx_value_r <= istk_r[0];
                // Subroutine returns keep the current bank and index
                ctx_mask_r  <= (instr_op == OP_IRQ_RETURN_INSTR) ? CTX_ALL_MASK
                                                     : CTX_RET_MASK;
            end
        end
    end

    // ==========================================================
    // APB slave, zero wait states, answer registered in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_en_r <= SRC_EN_RST;
        end else if (wr_en && paddr == REG_SRC_ENABLE) begin
            src_en_r <= pwdata[NSRC-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r  <= psel & ~penable;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
            if (psel && !penable) begin
                case (paddr)
                    REG_SRC_ENABLE: prdata_r <= 32'(src_en_r);
                    REG_REQ_FLAGS:  prdata_r <= 32'(req_flag_r);
                    REG_STATUS: begin
                        prdata_r[ST_GIE_BIT]                        <= gie_r;
                        prdata_r[ST_ICYC_BIT]                       <= icyc_r;
                        prdata_r[ST_SP_LSB +: SP_W]                 <= sp_r;
                        prdata_r[ST_IDEPTH_LSB +: ISTK_D_W]         <= idepth_r;
                        prdata_r[ST_WIN_LSB +: SRC_IDX_W]           <= win_idx_r;
                    end
                    default:        pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = pslverr_r;
    assign instr_tick           = tick_r;
    assign irq_cycle            = icyc_r;
    assign global_irq_enable_ff = gie_r;
    assign pc_load              = pc_load_r;
    assign pc_value             = pc_value_r;
    assign ctx_load             = ctx_load_r;
    assign ctx_value            = ctx_value_r;
    assign ctx_mask             = ctx_mask_r;
    assign stack_ptr            = sp_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_accept;
        accept_now;
    endsequence

    sequence s_entry_done;
        ##179 (pc_load_r && !icyc_r);
    endsequence

    property p_gate_all;
        accept_now |-> gie_r && pend_w[win_w];
    endproperty
    a_gate_all: assert property (p_gate_all) else $error("accept without all enables");

    property p_ei_late;
        boundary && instr_op == OP_EI && !gie_r && !any_sys_rst |-> !accept_now ##1 gie_r;
    endproperty
    a_ei_late: assert property (p_ei_late) else $error("enable took effect early");

    property p_di_now;
        boundary && instr_op == OP_DI |-> !accept_now ##1 !gie_r;
    endproperty
    a_di_now: assert property (p_di_now) else $error("disable did not block at once");

    property p_accept_clear;
        s_accept and !src_event[win_w] |=> !gie_r && !req_flag_r[win_idx_r] && icyc_r;
    endproperty
    a_accept_clear: assert property (p_accept_clear) else $error("accept left flags set");

    property p_sys_reset;
        any_sys_rst |=> !gie_r;
    endproperty
    a_sys_reset: assert property (p_sys_reset) else $error("system reset kept enable");

    property p_stop_keep;
        boundary && instr_op == OP_STOP && !accept_now && !any_sys_rst |=> $stable(gie_r);
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("clock stop changed enable");

    property p_event_set;
        |src_event |=> (req_flag_r & $past(src_event)) == $past(src_event);
    endproperty
    a_event_set: assert property (p_event_set) else $error("event lost");

    property p_priority;
        accept_now |-> (pend_w & ((NSRC'(1) << win_w) - NSRC'(1))) == '0;
    endproperty
    a_priority: assert property (p_priority) else $error("lower source won");

    property p_defer;
        boundary && defer_w |-> !accept_now;
    endproperty
    a_defer: assert property (p_defer) else $error("accept inside deferred cycle");

    property p_entry_time;
        s_accept |-> s_entry_done;
    endproperty
    a_entry_time: assert property (p_entry_time) else $error("entry not one cycle");

    property p_entry_stack;
        s_accept |-> ##179 (sp_r == $past(sp_r) - SP_W'(1) &&
                            pc_value_r == vector_of(win_idx_r) &&
                            astk_r[sp_r] == saved_pc_r);
    endproperty
    a_entry_stack: assert property (p_entry_stack) else $error("entry push wrong");

    property p_saved_pc;
        accept_now |=> saved_pc_r == $past(next_pc);
    endproperty
    a_saved_pc: assert property (p_saved_pc) else $error("return address wrong");

    property p_irq_return_instr;
        boundary && instr_op == OP_IRQ_RETURN_INSTR |=>
            pc_load_r && ctx_load_r && pc_value_r == $past(top_pc_w) &&
            sp_r == $past(sp_r) + SP_W'(1) && ctx_mask_r == CTX_ALL_MASK;
    endproperty
    a_irq_return_instr: assert property (p_irq_return_instr) else $error("interrupt return wrong");

    property p_ret;
        boundary && (instr_op == OP_RET || instr_op == OP_SUBROUTINE_RETURN_SKIP_INSTR) |=>
            ctx_load_r && ctx_mask_r == CTX_RET_MASK;
    endproperty
    a_ret: assert property (p_ret) else $error("subroutine return restored bank");

endmodule

// ---- logic/iaseq_pkg.sv ----
// Constants, types and register map of the interrupt accept sequencer
package iaseq_pkg;

    // ==========================================================
    // Timing
    localparam real INSTR_TIME_US = 1.78;
    localparam real CLK_MHZ       = 100.0;
    localparam int  ICYC_CYCLES   = $rtoi(INSTR_TIME_US * CLK_MHZ + 0.5);
    localparam int  ICYC_CNT_W    = 8;
    localparam logic [ICYC_CNT_W-1:0] ICYC_LAST = ICYC_CNT_W'(ICYC_CYCLES - 1);

    // ==========================================================
    // Sizes
    localparam int NSRC      = 12;
    localparam int SRC_IDX_W = 4;
    localparam int PC_W      = 14;
    localparam int CTX_W     = 16;
    localparam int SP_W      = 3;
    localparam int ASTK_N    = 8;
    localparam int ISTK_N    = 4;
    localparam int ISTK_D_W  = 3;

    // ==========================================================
    // Reset values
    localparam logic [SP_W-1:0] SP_RST     = 3'h7;
    localparam logic [NSRC-1:0] SRC_EN_RST = 12'h000;

    // ==========================================================
    // Context fields: bank in [3:0], index in [11:4]
    localparam logic [CTX_W-1:0] CTX_ALL_MASK = 16'hFFFF;
    localparam logic [CTX_W-1:0] CTX_RET_MASK = 16'hF000;

    // Default vector table, source 0 in the low slice
    localparam logic [NSRC*PC_W-1:0] VEC_DEFAULT = {
        14'h002C, 14'h0028, 14'h0024, 14'h0020, 14'h001C, 14'h0018,
        14'h0014, 14'h0010, 14'h000C, 14'h0008, 14'h0004, 14'h0001};

    // ==========================================================
    // APB map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_SRC_ENABLE = 8'h00;
    localparam logic [ADDR_W-1:0] REG_REQ_FLAGS  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h08;
    localparam int ST_GIE_BIT    = 0;
    localparam int ST_ICYC_BIT   = 1;
    localparam int ST_SP_LSB     = 4;
    localparam int ST_IDEPTH_LSB = 8;
    localparam int ST_WIN_LSB    = 12;

    // ==========================================================
    // Instruction finishing at each boundary
    typedef enum logic [3:0] {
        OP_NORMAL,
        OP_EI,
        OP_DI,
        OP_MOVT1,
        OP_SKIP,
        OP_IRQ_RETURN_INSTR,
        OP_RET,
        OP_SUBROUTINE_RETURN_SKIP_INSTR,
        OP_STOP
    } iaseq_op_t;

endpackage

// ---- testbench/iaseq_seq_model.sv ----
// Instruction sequencer model facing the accept sequencer
`timescale 1ns/1ps
module iaseq_seq_model
    import iaseq_pkg::*;
(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             instr_tick,
    input  wire logic             pc_load,
    input  wire logic [PC_W-1:0]  pc_value,
    input  wire iaseq_op_t        op_req,
    output iaseq_op_t             instr_op,
    output logic      [PC_W-1:0]  next_pc,
    output logic      [CTX_W-1:0] sys_ctx
);
    // ==========================================
    // Context follows the address so saves are traceable
    assign instr_op = op_req;
    assign sys_ctx  = {2'h0, next_pc} ^ 16'h5A5A;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_pc <= 14'h0100;
        end else if (pc_load) begin
            next_pc <= pc_value;
        end else if (instr_tick) begin
            next_pc <= next_pc + 14'h0001;
        end
    end
endmodule

// ---- testbench/tb_interrupt_accept_sequencer.sv ----
// Self-checking bench for the interrupt accept sequencer
`timescale 1ns/1ps
module tb_interrupt_accept_sequencer;
    import iaseq_pkg::*;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic             instr_tick, irq_cycle, gie, pc_load, ctx_load;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, rd;
    logic [11:0]      src_event;
    logic [3:0]       srst;
    logic [PC_W-1:0]  next_pc, pc_value, px;
    logic [CTX_W-1:0] sys_ctx, ctx_value, ctx_mask, cx;
    logic [2:0]       stack_ptr, sp_e;
    iaseq_op_t        op_req, instr_op;
    logic [PC_W-1:0]  pcq[$];
    logic [CTX_W-1:0] cxq[$];
    int               n_mismatch, checks_done, cyc;

    iaseq_top iaseq_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_event(src_event), .pin_reset(srst[0]), .wdt_reset(srst[1]),
        .stack_fault_reset(srst[2]), .ce_reset(srst[3]), .instr_op(instr_op),
        .next_pc(next_pc), .sys_ctx(sys_ctx), .instr_tick(instr_tick), .irq_cycle(irq_cycle),
        .global_irq_enable_ff(gie), .pc_load(pc_load), .pc_value(pc_value),
        .ctx_load(ctx_load), .ctx_value(ctx_value), .ctx_mask(ctx_mask),
        .stack_ptr(stack_ptr));
    iaseq_seq_model iaseq_seq_model_i (.pclk(pclk), .presetn(presetn),
        .instr_tick(instr_tick), .pc_load(pc_load), .pc_value(pc_value), .op_req(op_req),
        .instr_op(instr_op), .next_pc(next_pc), .sys_ctx(sys_ctx));

    // ==========================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Ends when pready is seen high; the bench timeout ends it if pready never comes
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for a boundary outside the interrupt cycle, op applied there
    task automatic step(input iaseq_op_t op);
        @(posedge pclk);
        op_req <= op;
        do begin
            @(posedge pclk);
        end while (!(instr_tick === 1'b1 && irq_cycle === 1'b0));
        px = next_pc;
        cx = sys_ctx;
        op_req <= OP_NORMAL;
        #1;
    endtask
    task automatic ev(input logic [11:0] b);
        @(posedge pclk);
        src_event <= b;
        @(posedge pclk);
        src_event <= 12'h000;
    endtask
    task automatic took(input int s);
        int n;
        chk("irq_cycle", 32'(irq_cycle), 32'h1);
        chk("gie_acc", 32'(gie), 32'h0);
        pcq.push_back(px);
        cxq.push_back(cx);
        n = 0;
        while (pc_load !== 1'b1 && n < 400) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk("entry_len", 32'(n), 32'(ICYC_CYCLES));
        chk("vector", 32'(pc_value), 32'(VEC_DEFAULT[s*PC_W +: PC_W]));
        sp_e = sp_e - 3'h1;
        chk("sp_dec", 32'(stack_ptr), 32'(sp_e));
        apb(1'b0, REG_STATUS, 32'h0);
        chk("winner", 32'(rd[ST_WIN_LSB +: 4]), 32'(s));
    endtask
    task automatic ret(input iaseq_op_t op, input logic [15:0] m);
        step(op);
        sp_e = sp_e + 3'h1;
        chk("ret_load", 32'({pc_load, ctx_load}), 32'h3);
        chk("ret_pc", 32'(pc_value), 32'(pcq.pop_back()));
        chk("ctx_mask", 32'(ctx_mask), 32'(m));
        // Only the interrupt return pops the context stack
        chk("ctx_val", 32'(ctx_value), 32'((op == OP_IRQ_RETURN_INSTR) ? cxq.pop_back() : cxq[$]));
        chk("sp_inc", 32'(stack_ptr), 32'(sp_e));
    endtask

    // ==========================================
    // Clock, timeout and sequence
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, src_event, srst} = '0;
        op_req = OP_NORMAL;
        sp_e = SP_RST;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REG_STATUS, 32'h0);
        chk("status_rst", rd, 32'(SP_RST) << ST_SP_LSB);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", {err, rd[30:0]}, 32'h80000000);
        apb(1'b1, REG_SRC_ENABLE, 32'hFFFFFFFF);
        apb(1'b0, REG_SRC_ENABLE, 32'h0);
        chk("enables", rd, 32'h00000FFF);
        ev(12'h042);
        apb(1'b0, REG_REQ_FLAGS, 32'h0);
        chk("flags", rd, 32'h00000042);
        step(OP_NORMAL);
        chk("gie_off", 32'(irq_cycle), 32'h0);
        step(OP_EI);
        chk("ei_delay", 32'({gie, irq_cycle}), 32'h2);
        step(OP_NORMAL);
        took(1);
        apb(1'b0, REG_REQ_FLAGS, 32'h0);
        chk("flag_clr", rd, 32'h00000040);
        // Higher source masked so the lower one goes first
        apb(1'b1, REG_SRC_ENABLE, 32'h00000FBF);
        ev(12'h800);
        step(OP_EI);
        step(OP_NORMAL);
        took(11);
        // Source 6 pending and enabled, so the disable must block it
        apb(1'b1, REG_SRC_ENABLE, 32'h00000FFF);
        step(OP_EI);
        step(OP_DI);
        chk("di", 32'({gie, irq_cycle}), 32'h0);
        step(OP_EI);
        step(OP_MOVT1);
        chk("table_read_instr_wait", 32'(irq_cycle), 32'h0);
        step(OP_NORMAL);
        took(6);
        ev(12'h001);
        step(OP_EI);
        step(OP_SKIP);
        chk("skip_wait", 32'(irq_cycle), 32'h0);
        step(OP_NORMAL);
        took(0);
        step(OP_EI);
        step(OP_STOP);
        chk("stop_keep", 32'(gie), 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            srst <= 4'h1 << i;
            @(posedge pclk);
            srst <= 4'h0;
            #1;
            chk("sync_rst", 32'(gie), 32'h0);
            step(OP_EI);
        end
        apb(1'b0, REG_STATUS, 32'h0);
        chk("nest_depth", 32'(rd[ST_IDEPTH_LSB +: 3]), 32'(ISTK_N));
        ret(OP_IRQ_RETURN_INSTR, 16'hFFFF);
        ret(OP_RET, 16'hF000);
        ret(OP_SUBROUTINE_RETURN_SKIP_INSTR, 16'hF000);
        ret(OP_IRQ_RETURN_INSTR, 16'hFFFF);
        end_of_test();
    end
endmodule
